// >>> inc/spi_port_pkg.sv
// constants, field layout and pin carriers of the serial port
// assumes a 16-bit register view mapped into 32-bit aligned bus words
package spi_port_pkg;

  // ==========================================================
  // register map and widths
  localparam int REG_W = 16;
  localparam int WORD_LONG = 16;
  localparam int WORD_SHORT = 8;
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_CON1 = 4'h4;
  localparam logic [3:0] OFF_CON2 = 4'h8;
  localparam logic [3:0] OFF_BUF = 4'hC;
  localparam logic [15:0] RST_VALUE = 16'h0000;

  // ==========================================================
  // field positions
  localparam int BIT_MODULE_ENABLE = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_RX_OVERFLOW = 6;
  localparam int BIT_TX_FULL = 1;
  localparam int BIT_RX_FULL = 0;
  localparam int BIT_CLOCK_PIN_DISABLE = 12;
  localparam int BIT_DATA_OUT_DISABLE = 11;
  localparam int BIT_WORD_SIZE = 10;
  localparam int BIT_SAMPLE_PHASE = 9;
  localparam int BIT_CLOCK_EDGE = 8;
  localparam int BIT_SLAVE_SELECT_ENABLE = 7;
  localparam int BIT_CLOCK_POLARITY = 6;
  localparam int BIT_MASTER_SELECT = 5;
  localparam int SEC_LSB = 2;
  localparam int PRI_LSB = 0;
  localparam int BIT_FRAMED = 15;
  localparam int BIT_FSYNC_DIR = 14;
  localparam int BIT_FSYNC_POL = 13;
  localparam int BIT_FSYNC_EDGE = 1;
  localparam logic [15:0] STAT_W_MASK = 16'hA000;
  localparam logic [15:0] CON1_W_MASK = 16'h1FFF;
  localparam logic [15:0] CON2_W_MASK = 16'hE002;
  localparam logic [15:0] BUF_W_MASK = 16'hFFFF;

  // ==========================================================
  // bus answers and prescale ratios
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [9:0] PRI_DIV_1 = 10'h001;
  localparam logic [9:0] PRI_DIV_4 = 10'h004;
  localparam logic [9:0] PRI_DIV_16 = 10'h010;
  localparam logic [9:0] PRI_DIV_64 = 10'h040;
  localparam logic [9:0] SEC_DIV_TOP = 10'h008;

  typedef struct packed {logic sck; logic sdi; logic ss;} pin_in_s;
  typedef struct packed {
    logic sck; logic sck_oe_n; logic sdo; logic sdo_oe_n; logic ss; logic ss_oe_n;
  } pin_out_s;
  typedef enum logic [1:0] {M_IDLE, M_SYNC, M_XFER} master_state_e;
  typedef enum logic [1:0] {F_NONE, F_PENDING, F_ARMED} frame_arm_e;

  // half clock period in core cycles
  function automatic logic [9:0] prescale_ratio(input logic [1:0] pri, input logic [2:0] sec);
    logic [9:0] p;
    logic [9:0] s;
    case (pri)
      2'h3: p = PRI_DIV_1;
      2'h2: p = PRI_DIV_4;
      2'h1: p = PRI_DIV_16;
      default: p = PRI_DIV_64;
    endcase
    s = SEC_DIV_TOP - {7'h00, sec};
    return 10'(p * s);
  endfunction

endpackage

// >>> hdl/spi_master_slave_port.sv
// serial port, master or slave, with an AXI4-Lite register slave
// assumes pins_in come from the pad ring unsynchronised; chip_idle is core logic
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module spi_master_slave_port #(
  parameter int AXI_ADDR_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_idle,
  input wire spi_port_pkg::pin_in_s pins_in,
  output spi_port_pkg::pin_out_s pins_out
);
  import spi_port_pkg::*;

  if (AXI_ADDR_W < 4) begin : g_bad_addr
    $error("address width too small for register map");
  end

  // ==========================================================
  // state
  logic [15:0] con1_q, con2_q, txbuf_q, rxbuf_q, shift_q, rx_q;
  logic en_q, sidl_q, rov_q, tbf_q, rbf_q;
  pin_in_s sync1_q, sync2_q;
  logic sck_prev_q;
  master_state_e mstate_q;
  frame_arm_e farm_q;
  logic [5:0] hcnt_q;
  logic [9:0] div_q;
  logic ph_q, fsync_q, mdone_q, sdone_q, loaded_q;
  logic [4:0] scnt_q;
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // ==========================================================
  // configuration decode
  wire master = con1_q[BIT_MASTER_SELECT];
  wire dis_sck = con1_q[BIT_CLOCK_PIN_DISABLE];
  wire dis_sdo = con1_q[BIT_DATA_OUT_DISABLE];
  wire word16 = con1_q[BIT_WORD_SIZE];
  wire sample_phase = con1_q[BIT_SAMPLE_PHASE];
  wire cke = con1_q[BIT_CLOCK_EDGE];
  wire slave_select_enable = con1_q[BIT_SLAVE_SELECT_ENABLE];
  wire clock_polarity = con1_q[BIT_CLOCK_POLARITY];
  wire framed = con2_q[BIT_FRAMED];
  wire fsd = con2_q[BIT_FSYNC_DIR];
  wire fpol = con2_q[BIT_FSYNC_POL];
  wire fedge = con2_q[BIT_FSYNC_EDGE];
  wire halt = sidl_q & chip_idle;
  wire run = en_q & ~halt;
  wire [4:0] word_bits = word16 ? 5'(WORD_LONG) : 5'(WORD_SHORT);
  wire [5:0] n2 = {word_bits, 1'b0};
  wire [9:0] ratio = prescale_ratio(con1_q[PRI_LSB+:2], con1_q[SEC_LSB+:3]);

  function automatic logic [2:0] decode_reg(input logic [AXI_ADDR_W-1:0] a);
    logic ok;
    ok = ((a >> 4) == '0) && (a[1:0] == OFF_STATUS[1:0]);
    return {ok, a[3:2]};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old & ~lanes) | (nw & lanes);
  endfunction

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk) begin
    sync1_q <= pins_in;
    sync2_q <= sync1_q;
    sck_prev_q <= sync2_q.sck;
  end

  // ==========================================================
  // register bus
  logic [15:0] status_v;
  always_comb begin
    status_v = RST_VALUE;
    status_v[BIT_MODULE_ENABLE] = en_q;
    status_v[BIT_IDLE_STOP] = sidl_q;
    status_v[BIT_RX_OVERFLOW] = rov_q;
    status_v[BIT_TX_FULL] = tbf_q;
    status_v[BIT_RX_FULL] = rbf_q;
  end

  wire [2:0] wsel = decode_reg(awaddr_q);
  wire [2:0] rsel = decode_reg(s_axi_araddr);
  wire wr_do = aw_have_q & w_have_q & ~bvalid_q;
  wire rd_do = arready_q & s_axi_arvalid;
  wire [15:0] wd = wdata_q[15:0];
  wire [1:0] wst = wstrb_q[1:0];
  wire wr_stat = wr_do & wsel[2] & (wsel[1:0] == OFF_STATUS[3:2]);
  wire wr_con1 = wr_do & wsel[2] & (wsel[1:0] == OFF_CON1[3:2]);
  wire wr_con2 = wr_do & wsel[2] & (wsel[1:0] == OFF_CON2[3:2]);
  wire buf_wr = wr_do & wsel[2] & (wsel[1:0] == OFF_BUF[3:2]) & (|wst);
  wire buf_rd = rd_do & rsel[2] & (rsel[1:0] == OFF_BUF[3:2]);
  wire rov_clr = wr_stat & wst[0] & ~wd[BIT_RX_OVERFLOW];
  wire [15:0] stat_new = merge16(status_v, wd, wst, STAT_W_MASK);

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b0;
      awaddr_q <= '0;
    end else if (awready_q && s_axi_awvalid) begin
      aw_have_q <= 1'b1;
      awready_q <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else begin
      if (wr_do) aw_have_q <= 1'b0;
      awready_q <= ~aw_have_q & ~bvalid_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wready_q && s_axi_wvalid) begin
      w_have_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else begin
      if (wr_do) w_have_q <= 1'b0;
      wready_q <= ~w_have_q & ~bvalid_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= wsel[2] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_do) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rsel[2] ? RESP_OKAY : RESP_SLVERR;
      case (rsel)
        {1'b1, OFF_STATUS[3:2]}: rdata_q <= {16'h0000, status_v};
        {1'b1, OFF_CON1[3:2]}: rdata_q <= {16'h0000, con1_q};
        {1'b1, OFF_CON2[3:2]}: rdata_q <= {16'h0000, con2_q};
        {1'b1, OFF_BUF[3:2]}: rdata_q <= {16'h0000, rxbuf_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      if (s_axi_rready) rvalid_q <= 1'b0;
      arready_q <= ~rvalid_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      con1_q <= RST_VALUE;
      con2_q <= RST_VALUE;
      en_q <= 1'b0;
      sidl_q <= 1'b0;
    end else begin
      if (wr_con1) con1_q <= merge16(con1_q, wd, wst, CON1_W_MASK);
      if (wr_con2) con2_q <= merge16(con2_q, wd, wst, CON2_W_MASK);
      if (wr_stat) begin
        en_q <= stat_new[BIT_MODULE_ENABLE];
        sidl_q <= stat_new[BIT_IDLE_STOP];
      end
    end
  end

  // ==========================================================
  // transfer strobes
  wire [5:0] ev = hcnt_q;
  wire [5:0] last_ev = (!cke && sample_phase) ? n2 : n2 - 6'h01;
  wire tick = (div_q == ratio - 10'h001);
  wire m_run = run & master;
  wire m_ev = m_run & (mstate_q == M_XFER) & tick;
  wire fsync_in = (sync2_q.ss == fpol);
  wire f_go = framed ? (tick & ph_q & (fsd ? fsync_in : tbf_q)) : tbf_q;
  wire m_start = m_run & (mstate_q == M_IDLE) & f_go;
  wire m_load = m_start & tbf_q;
  wire m_shift = m_ev & (cke ? (ev[0] && ev != last_ev)
                             : (!ev[0] && ev != 6'h00 && ev < n2));
  wire m_sample = m_ev & (sample_phase ? (cke ? ev[0] : (!ev[0] && ev != 6'h00))
                              : (cke ? !ev[0] : ev[0]));
  wire m_last = m_ev & (ev == last_ev);
  wire ss_block = slave_select_enable & sync2_q.ss & ~framed;
  wire s_live = run & ~master & ~ss_block;
  wire lead = (sync2_q.sck ^ clock_polarity) & ~(sck_prev_q ^ clock_polarity);
  wire trail = ~(sync2_q.sck ^ clock_polarity) & (sck_prev_q ^ clock_polarity);
  wire f_new = framed & lead & (farm_q == F_NONE) & fsync_in;
  wire s_data = ~framed | (farm_q == F_ARMED) | (f_new & fedge);
  wire s_lead = s_live & lead & s_data;
  wire s_trail = s_live & trail & s_data;
  wire s_sample = cke ? s_lead : s_trail;
  wire s_shift = (cke ? s_trail : s_lead) & (scnt_q != 5'h00);
  wire s_load = s_live & ~loaded_q & tbf_q;
  wire s_last = s_sample & (scnt_q == word_bits - 5'h01);
  wire do_load = m_load | s_load;
  wire word_done = mdone_q | sdone_q;
  wire [15:0] rx_word = word16 ? rx_q : {8'h00, rx_q[7:0]};
  wire sdo_bit = word16 ? shift_q[15] : shift_q[7];

  // ==========================================================
  // master clock engine
  always_ff @(posedge clk) begin
    if (rst || !en_q || !master) begin
      mstate_q <= M_IDLE;
      hcnt_q <= '0;
      div_q <= '0;
      ph_q <= 1'b0;
      fsync_q <= 1'b0;
      mdone_q <= 1'b0;
    end else if (!halt) begin
      mdone_q <= m_last;
      if (mstate_q != M_IDLE || framed) div_q <= tick ? 10'h000 : div_q + 10'h001;
      else div_q <= '0;
      if (tick && (framed || mstate_q == M_SYNC || (mstate_q == M_XFER && ev < n2)))
        ph_q <= ~ph_q;
      case (mstate_q)
        M_IDLE: begin
          if (m_start) begin
            hcnt_q <= '0;
            fsync_q <= framed & ~fsd;
            mstate_q <= (framed && !fsd && !fedge) ? M_SYNC : M_XFER;
          end
        end
        M_SYNC: begin
          if (tick) begin
            hcnt_q <= (ev == 6'h01) ? 6'h00 : ev + 6'h01;
            if (ev == 6'h01) begin
              fsync_q <= 1'b0;
              mstate_q <= M_XFER;
            end
          end
        end
        M_XFER: begin
          if (tick) begin
            hcnt_q <= ev + 6'h01;
            if (ev == 6'h01) fsync_q <= 1'b0;
            if (ev == last_ev) mstate_q <= M_IDLE;
          end
        end
        default: mstate_q <= M_IDLE;
      endcase
    end
  end

  // ==========================================================
  // slave bit engine
  always_ff @(posedge clk) begin
    if (rst || !en_q || master) begin
      scnt_q <= '0;
      loaded_q <= 1'b0;
      farm_q <= F_NONE;
      sdone_q <= 1'b0;
    end else if (!halt) begin
      sdone_q <= s_last;
      if (ss_block) begin
        scnt_q <= '0;
        loaded_q <= 1'b0;
      end else begin
        if (!loaded_q) loaded_q <= 1'b1;
        if (f_new) farm_q <= fedge ? F_ARMED : F_PENDING;
        else if (lead && farm_q == F_PENDING) farm_q <= F_ARMED;
        if (s_sample) scnt_q <= s_last ? 5'h00 : scnt_q + 5'h01;
        if (s_last) begin
          loaded_q <= 1'b0;
          farm_q <= F_NONE;
        end
      end
    end
  end

  // ==========================================================
  // data path and flags
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= '0;
      rx_q <= '0;
    end else begin
      if (do_load) shift_q <= txbuf_q;
      else if (m_shift || s_shift) shift_q <= shift_q << 1;
      if (m_sample || s_sample) rx_q <= {rx_q[14:0], sync2_q.sdi};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txbuf_q <= '0;
      tbf_q <= 1'b0;
    end else begin
      if (buf_wr) txbuf_q <= merge16(txbuf_q, wd, wst, BUF_W_MASK);
      if (buf_wr) tbf_q <= 1'b1;
      else if (do_load) tbf_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxbuf_q <= '0;
      rbf_q <= 1'b0;
      rov_q <= 1'b0;
    end else begin
      if (word_done && !rbf_q) rxbuf_q <= rx_word;
      if (word_done && !rbf_q) rbf_q <= 1'b1;
      else if (buf_rd) rbf_q <= 1'b0;
      if (word_done && rbf_q) rov_q <= 1'b1;
      else if (rov_clr) rov_q <= 1'b0;
    end
  end

  // ==========================================================
  // pins and bus outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_out <= '{sck: 1'b0, sck_oe_n: 1'b1, sdo: 1'b0, sdo_oe_n: 1'b1,
                    ss: 1'b1, ss_oe_n: 1'b1};
    end else begin
      pins_out.sck <= clock_polarity ^ ph_q;
      pins_out.sck_oe_n <= ~(en_q & master & ~dis_sck);
      pins_out.sdo <= sdo_bit;
      pins_out.sdo_oe_n <= ~(en_q & ~dis_sdo & ~(~master & ss_block));
      pins_out.ss <= fsync_q ? fpol : ~fpol;
      pins_out.ss_oe_n <= ~(en_q & framed & ~fsd & master);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // checks
  logic [4:0] samp_cnt_q;
  always_ff @(posedge clk) begin
    if (rst || !en_q || word_done) samp_cnt_q <= '0;
    else if (m_sample || s_sample) samp_cnt_q <= samp_cnt_q + 5'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tbf_on_write: assert property (buf_wr |=> tbf_q)
    else $error("tx full not set by write");
  a_load_empties: assert property (do_load && !buf_wr |=> !tbf_q && shift_q == $past(txbuf_q))
    else $error("load did not empty tx buffer");
  a_rbf_on_word: assert property (word_done && !rbf_q |=> rbf_q && rxbuf_q == $past(rx_word))
    else $error("received word not stored");
  a_overflow_drop: assert property (word_done && rbf_q |=> rov_q && $stable(rxbuf_q))
    else $error("overflow not flagged or word not dropped");
  a_rbf_read_clr: assert property (buf_rd && !word_done |=> !rbf_q)
    else $error("rx full not cleared by read");
  a_sck_released: assert property (en_q && master && dis_sck |=> pins_out.sck_oe_n)
    else $error("clock pin driven while disabled");
  a_sdo_released: assert property (dis_sdo |=> pins_out.sdo_oe_n)
    else $error("data pin driven while disabled");
  a_pins_off: assert property (!en_q |=> pins_out.sck_oe_n && pins_out.sdo_oe_n
                                         && pins_out.ss_oe_n)
    else $error("pins driven while module off");
  a_idle_freeze: assert property (halt && en_q ##1 en_q |-> $stable(hcnt_q) && $stable(ph_q))
    else $error("engine moved during idle stop");
  a_sck_idle_lvl: assert property (en_q && master && !framed && mstate_q == M_IDLE
                                    |=> pins_out.sck == $past(clock_polarity))
    else $error("clock not at idle level");
  a_ss_ignore: assert property (!master && run && ss_block |=> scnt_q == 5'h00
                                 && pins_out.sdo_oe_n)
    else $error("deselected slave active");
  a_word_len: assert property (word_done |-> samp_cnt_q == word_bits)
    else $error("wrong number of bits in word");

  c_master_word: cover property (mdone_q && word16);
  c_slave_word: cover property (sdone_q && slave_select_enable);
  c_overflow: cover property (word_done && rbf_q);
  c_framed_word: cover property (mdone_q && framed);

endmodule

// >>> tb/spi_peer.sv
// remote serial device model: shifts a word out and in
// assumes resolved pins; as a master it gates its own clock and select
`timescale 1ns/1ps
module spi_peer (
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  output logic sck_drv,
  output logic ss_n
);
  // ==========================================================
  // shift logic
  logic [31:0] tx_q = 32'h0;
  logic [15:0] rx_q = 16'h0;
  initial sdi = 1'b0;
  initial sck_drv = 1'b0;
  initial ss_n = 1'b1;
  // ==========================================================
  // frame driver
  // 125 ns clock only inside a frame, off the core clock edges
  task automatic frame(input int n, input logic sel);
    ss_n <= ~sel;
    #251;
    repeat (n) begin
      #62.5 sck_drv = 1'b1;
      #62.5 sck_drv = 1'b0;
    end
    #250;
    ss_n <= 1'b1;
  endtask
  // next bit on leading edge, msb first
  always @(posedge sck) begin
    sdi <= tx_q[31];
    tx_q <= {tx_q[30:0], 1'b0};
  end
  // sample on trailing edge
  always @(negedge sck) begin
    rx_q <= {rx_q[14:0], sdo};
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench: AXI4-Lite register tests, master transfers and a slave transfer
// assumes the port package and the peer model are compiled first
`timescale 1ns/1ps
module testbench;
  import spi_port_pkg::*;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic chip_idle = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  pin_in_s pin_i;
  pin_out_s pin_o;
  logic sck_w;
  logic sdo_w;
  logic peer_sck;
  logic peer_ss_n;
  logic sdi;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [1:0] r;
  always #2.5 clk = ~clk;
  assign sck_w = pin_o.sck_oe_n ? peer_sck : pin_o.sck;
  assign sdo_w = pin_o.sdo_oe_n ? ~pin_o.sdo : pin_o.sdo;
  assign pin_i = '{sck: sck_w, sdi: sdi, ss: peer_ss_n};
  spi_master_slave_port dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chip_idle(chip_idle), .pins_in(pin_i), .pins_out(pin_o));
  spi_peer peer (.sck(sck_w), .sdo(sdo_w), .sdi(sdi), .sck_drv(peer_sck),
    .ss_n(peer_ss_n));
  // ==========================================================
  // tasks
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic ad;
    logic dd;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready === 1'b1) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    e = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    rd(a, v, r);
    chk(v, exp);
  endtask
  task automatic poll(input int b);
    do rd(OFF_STATUS, v, r); while (v[b] !== 1'b1);
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(OFF_STATUS, 32'h0);
    rdc(OFF_CON1, 32'h0);
    rdc(OFF_CON2, 32'h0);
    chk({30'h0, pin_o.sck_oe_n, pin_o.sdo_oe_n}, 32'h3);
    rd(4'h2, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // master, 16-bit, ratio 12, preload peer before start
    wr(OFF_CON1, 16'h0436);
    wr(OFF_STATUS, 16'h8000);
    repeat (2) @(posedge clk);
    chk({30'h0, pin_o.sck_oe_n, pin_o.sck}, 32'h0);
    peer.tx_q = 32'hA5C3_3C5A;
    wr(OFF_BUF, 16'h1234);
    wr(OFF_BUF, 16'h5678);
    rdc(OFF_STATUS, 32'h8002);
    poll(BIT_RX_FULL);
    chk({16'h0, peer.rx_q}, 32'h1234);
    rdc(OFF_BUF, 32'hA5C3);
    poll(BIT_RX_FULL);
    chk({16'h0, peer.rx_q}, 32'h5678);
    wr(OFF_BUF, 16'h0F0F);
    poll(BIT_RX_OVERFLOW);
    rdc(OFF_STATUS, 32'h8041);
    rdc(OFF_BUF, 32'h3C5A);
    wr(OFF_STATUS, 16'h8000);
    rdc(OFF_STATUS, 32'h8000);
    // byte words
    wr(OFF_CON1, 16'h0036);
    peer.tx_q = 32'h9600_0000;
    wr(OFF_BUF, 16'h00C7);
    poll(BIT_RX_FULL);
    chk({24'h0, peer.rx_q[7:0]}, 32'hC7);
    rd(OFF_BUF, v, r);
    chk({24'h0, v[7:0]}, 32'h96);
    // sampling at end of output time, set with master select
    wr(OFF_CON1, 16'h0236);
    peer.tx_q = 32'h3C00_0000;
    wr(OFF_BUF, 16'h00A9);
    poll(BIT_RX_FULL);
    chk({24'h0, peer.rx_q[7:0]}, 32'hA9);
    rd(OFF_BUF, v, r);
    chk({24'h0, v[7:0]}, 32'h3C);
    // idle stop freezes the port
    wr(OFF_STATUS, 16'hA000);
    chip_idle <= 1'b1;
    peer.tx_q = 32'h5A00_0000;
    wr(OFF_BUF, 16'h0011);
    repeat (200) @(posedge clk);
    rdc(OFF_STATUS, 32'hA002);
    chip_idle <= 1'b0;
    poll(BIT_RX_FULL);
    rd(OFF_BUF, v, r);
    chk({24'h0, v[7:0]}, 32'h5A);
    // pin releases and clock polarity
    wr(OFF_CON1, 16'h1836);
    repeat (2) @(posedge clk);
    chk({30'h0, pin_o.sck_oe_n, pin_o.sdo_oe_n}, 32'h3);
    wr(OFF_CON1, 16'h0076);
    repeat (2) @(posedge clk);
    chk({30'h0, pin_o.sck_oe_n, pin_o.sck}, 32'h1);
    wr(OFF_STATUS, 16'h0000);
    repeat (2) @(posedge clk);
    chk({30'h0, pin_o.sck_oe_n, pin_o.sdo_oe_n}, 32'h3);
    // slave with select pin, peer clock gated per frame
    wr(OFF_CON1, 16'h0480);
    wr(OFF_STATUS, 16'h8000);
    wr(OFF_BUF, 16'hB38E);
    peer.frame(4, 1'b0);
    chk({31'h0, pin_o.sdo_oe_n}, 32'h1);
    rdc(OFF_STATUS, 32'h8002);
    peer.tx_q = 32'h6D29_0000;
    peer.frame(16, 1'b1);
    poll(BIT_RX_FULL);
    chk({16'h0, peer.rx_q}, 32'hB38E);
    rdc(OFF_BUF, 32'h6D29);
    complete_run();
  end
endmodule
